//--- can_command_register.sv
`timescale 1ns/1ns
`default_nettype none
`include "can_cmd_map.svh"
module can_command_register
  import can_cmd_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // wake detectors from the bus pins (asynchronous)
  input wire logic bus_input_a_active,
  input wire logic bus_input_b_active,
  input wire logic bus_diff_active,
  // protocol engine status (same clock)
  input wire logic tx_started,
  input wire logic tx_in_progress,
  input wire logic tx_done,
  input wire logic rx_message_store,
  input wire logic irq_pending,
  input wire logic bus_idle,
  input wire logic bus_free,
  // command pulses to the protocol engine
  output logic transmit_request_cmd,
  output logic abort_transmit_cmd,
  output logic release_rx_buffer_cmd,
  output logic clear_overrun_cmd,
  // levels to the protocol engine and analogue front end
  output logic tx_pending,
  output logic rx_enable,
  output logic rx_drop,
  output logic wake_irq,
  output logic comparator_a_from_bus,
  output logic comparator_b_from_bus,
  // flags
  output logic transmit_complete_flag,
  output logic transmit_buffer_free_flag,
  output logic rx_buffer_full_flag,
  output logic data_overrun_flag,
  output logic sleeping
);
  reg_port_if port ();

  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_d;
  logic cmd_write;
  reg_byte_t cmd_byte;
  logic sleep_request;
  logic wake_source_select;
  logic bus_input_a_switch_on;
  logic bus_input_b_switch_on;
  logic rx_buffer_zero;
  logic rx_buffer_one;
  logic attached;
  logic wake_by_bus;
  logic next_zero;
  logic next_one;
  logic next_attached;
  logic store_ok;

  // tests one command bit of the current register write
  function automatic logic cmd_bit(input logic wr, input reg_byte_t d, input int pos);
    cmd_bit = wr && d[pos];
  endfunction : cmd_bit

  can_cmd_axil bus_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .port(port.bus)
  );

  // detector pins are asynchronous; two flops before anything looks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      sync_d <= 2'h0;
    end
    else if (ce)
    begin
      sync_a <= {sync_a[0], bus_input_a_active};
      sync_b <= {sync_b[0], bus_input_b_active};
      sync_d <= {sync_d[0], bus_diff_active};
    end
  end

  can_sleep_ctrl sleep_ctrl (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sleep_request(sleep_request),
    .wake_source_select(wake_source_select),
    .irq_pending(irq_pending),
    .bus_idle(bus_idle),
    .bus_free(bus_free),
    .activity_a(sync_a[1]),
    .activity_b(sync_b[1]),
    .activity_diff(sync_d[1]),
    .sleeping(sleeping),
    .rx_enable(rx_enable),
    .wake_irq(wake_irq),
    .wake_by_bus(wake_by_bus)
  );

  // register decode
  assign cmd_write = port.wr_pulse && (port.wr_index == `CMD_REG_INDEX);
  assign cmd_byte = port.wr_data;
  assign port.wr_hit = (port.wr_index == `CMD_REG_INDEX);

  // command pulses last only the write cycle, nothing is latched
  assign transmit_request_cmd = cmd_bit(cmd_write, cmd_byte, `CMD_TRANSMIT_REQUEST);
  assign abort_transmit_cmd = cmd_bit(cmd_write, cmd_byte, `CMD_ABORT_TRANSMIT);
  assign release_rx_buffer_cmd = cmd_bit(cmd_write, cmd_byte, `CMD_RELEASE_RX_BUFFER);
  assign clear_overrun_cmd = cmd_bit(cmd_write, cmd_byte, `CMD_CLEAR_OVERRUN);

  // stored control bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_request <= 1'h0;
      wake_source_select <= 1'h0;
    end
    else if (ce)
    begin
      if (cmd_write)
      begin
        sleep_request <= cmd_byte[`CMD_SLEEP_REQUEST];
        wake_source_select <= cmd_byte[`CMD_WAKE_SOURCE_SELECT];
      end
      else if (wake_by_bus)
        sleep_request <= 1'h0; // bus wake ends the request, else we would doze again
    end
  end

  // switches: 00 keeps the previous routing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {bus_input_a_switch_on, bus_input_b_switch_on} <= `SWITCH_RESET;
    else if (ce && cmd_write && (cmd_byte[`CMD_SWITCH_A] || cmd_byte[`CMD_SWITCH_B]))
      {bus_input_a_switch_on, bus_input_b_switch_on} <=
        {cmd_byte[`CMD_SWITCH_A], cmd_byte[`CMD_SWITCH_B]};
  end

  // a low route selects the half-supply reference for that comparator input
  assign comparator_a_from_bus = bus_input_a_switch_on;
  assign comparator_b_from_bus = bus_input_b_switch_on;

  // pending transmission: only abort or the engine's start removes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_pending <= 1'h0;
    else if (ce)
    begin
      if (transmit_request_cmd)
        tx_pending <= 1'h1;
      else if (tx_started)
        tx_pending <= 1'h0;
      else if (abort_transmit_cmd && !tx_in_progress)
        tx_pending <= 1'h0;
    end
  end

  assign transmit_buffer_free_flag = !tx_pending && !tx_in_progress;

  // complete flag; a finishing frame wins over a new request in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      transmit_complete_flag <= `TX_COMPLETE_RESET;
    else if (ce)
    begin
      if (tx_done)
        transmit_complete_flag <= 1'h1;
      else if (transmit_request_cmd)
        transmit_complete_flag <= 1'h0;
    end
  end

  // two receive buffers; the cpu sees the older full one
  always_comb
  begin
    next_zero = rx_buffer_zero;
    next_one = rx_buffer_one;
    next_attached = attached;
    if (release_rx_buffer_cmd)
    begin
      if (attached)
        next_one = 1'h0;
      else
        next_zero = 1'h0;
      next_attached = !attached; // the other buffer, possibly full already
    end
    store_ok = rx_message_store && !(rx_buffer_zero && rx_buffer_one);
    if (store_ok)
    begin
      // fill the attached buffer first, so a release exposes the older message
      if (!rx_buffer_zero && (!attached || rx_buffer_one))
        next_zero = 1'h1;
      else
        next_one = 1'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_buffer_zero <= 1'h0;
      rx_buffer_one <= 1'h0;
      attached <= 1'h0;
    end
    else if (ce)
    begin
      rx_buffer_zero <= next_zero;
      rx_buffer_one <= next_one;
      attached <= next_attached;
    end
  end

  // message arriving with both buffers full is dropped
  assign rx_drop = rx_message_store && rx_buffer_zero && rx_buffer_one;

  // overrun flag; an overrun in the clear cycle is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_overrun_flag <= 1'h0;
    else if (ce)
    begin
      if (rx_drop)
        data_overrun_flag <= 1'h1;
      else if (clear_overrun_cmd)
        data_overrun_flag <= 1'h0;
    end
  end

  // full flag; a store in the release cycle keeps it set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_buffer_full_flag <= 1'h0;
    else if (ce)
    begin
      if (store_ok)
        rx_buffer_full_flag <= 1'h1;
      else if (release_rx_buffer_cmd)
        rx_buffer_full_flag <= 1'h0;
    end
  end

  // read mux; releases need no spacing here, each pulse is acted on
  always_comb
  begin
    port.rd_data = 8'h00;
    port.rd_hit = 1'h1;
    if (port.rd_index == `CMD_REG_INDEX)
    begin
      port.rd_data[`CMD_SWITCH_A] = bus_input_a_switch_on;
      port.rd_data[`CMD_SWITCH_B] = bus_input_b_switch_on;
      port.rd_data[`CMD_WAKE_SOURCE_SELECT] = wake_source_select;
      port.rd_data[`CMD_SLEEP_REQUEST] = sleeping;
      port.rd_data[3:0] = `CMD_READ_ONES;
    end
    else if (port.rd_index == `STATUS_REG_INDEX)
    begin
      port.rd_data[`STAT_RX_BUFFER_FULL] = rx_buffer_full_flag;
      port.rd_data[`STAT_DATA_OVERRUN] = data_overrun_flag;
      port.rd_data[`STAT_TX_BUFFER_FREE] = transmit_buffer_free_flag;
      port.rd_data[`STAT_TX_COMPLETE] = transmit_complete_flag;
      port.rd_data[`STAT_SLEEPING] = sleeping;
      port.rd_data[`STAT_RX_ENABLED] = rx_enable;
    end
    else
      port.rd_hit = 1'h0;
  end
endmodule : can_command_register
`default_nettype wire

//--- can_cmd_map.svh
`ifndef CAN_CMD_MAP_SVH
`define CAN_CMD_MAP_SVH

// register indices; byte address is four times the index
`define CMD_REG_INDEX 6'h01
`define STATUS_REG_INDEX 6'h02

// command register fields
`define CMD_TRANSMIT_REQUEST 0
`define CMD_ABORT_TRANSMIT 1
`define CMD_RELEASE_RX_BUFFER 2
`define CMD_CLEAR_OVERRUN 3
`define CMD_SLEEP_REQUEST 4
`define CMD_WAKE_SOURCE_SELECT 5
`define CMD_SWITCH_B 6
`define CMD_SWITCH_A 7
`define CMD_READ_ONES 4'hF

// status register fields
`define STAT_RX_BUFFER_FULL 0
`define STAT_DATA_OVERRUN 1
`define STAT_TX_BUFFER_FREE 2
`define STAT_TX_COMPLETE 3
`define STAT_SLEEPING 4
`define STAT_RX_ENABLED 5

// reset values
`define SWITCH_RESET 2'h3
`define TX_COMPLETE_RESET 1'h1

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- can_cmd_pkg.sv
`default_nettype none
package can_cmd_pkg;
  typedef enum logic [1:0] {awake, asleep, wait_bus_free} sleep_state_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] reg_index_t;
endpackage : can_cmd_pkg
`default_nettype wire

//--- reg_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface reg_port_if;
  import can_cmd_pkg::*;
  logic wr_pulse;
  reg_index_t wr_index;
  reg_byte_t wr_data;
  reg_index_t rd_index;
  reg_byte_t rd_data;
  logic rd_hit;
  logic wr_hit;
  modport bus (output wr_pulse, output wr_index, output wr_data, output rd_index,
    input rd_data, input rd_hit, input wr_hit);
  modport regs (input wr_pulse, input wr_index, input wr_data, input rd_index,
    output rd_data, output rd_hit, output wr_hit);
endinterface : reg_port_if
`default_nettype wire

//--- can_cmd_axil.sv
`timescale 1ns/1ns
`default_nettype none
`include "can_cmd_map.svh"
module can_cmd_axil
  import can_cmd_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  reg_port_if.bus port
);
  logic aw_held;
  logic w_held;
  reg_index_t aw_index;
  reg_byte_t w_byte;
  logic w_lane0;

  // channels take one item each; a held item blocks its channel until the response
  assign awready = ce && !aw_held && !bvalid;
  assign wready = ce && !w_held && !bvalid;
  assign arready = ce && !rvalid;

  // capture write address and data independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      aw_index <= 6'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'h1;
        aw_index <= awaddr[7:2];
      end
      else if (port.wr_pulse)
        aw_held <= 1'h0;
      if (wvalid && wready)
      begin
        w_held <= 1'h1;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end
      else if (port.wr_pulse)
        w_held <= 1'h0;
    end
  end

  // a disabled byte lane makes the write harmless but still answered
  assign port.wr_pulse = ce && aw_held && w_held;
  assign port.wr_index = w_lane0 ? aw_index : 6'h3F;
  assign port.wr_data = w_byte;
  assign port.rd_index = araddr[7:2];

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'h0;
      bresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (port.wr_pulse)
      begin
        bvalid <= 1'h1;
        bresp <= (port.wr_hit || !w_lane0) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'h0;
    end
  end

  // read response one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'h0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'h1;
        rdata <= {24'h000000, port.rd_data};
        rresp <= port.rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'h0;
    end
  end
endmodule : can_cmd_axil
`default_nettype wire

//--- can_sleep_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module can_sleep_ctrl
  import can_cmd_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic sleep_request,
  input wire logic wake_source_select,
  input wire logic irq_pending,
  input wire logic bus_idle,
  input wire logic bus_free,
  // synchronised activity detectors
  input wire logic activity_a,
  input wire logic activity_b,
  input wire logic activity_diff,
  // results
  output logic sleeping,
  output logic rx_enable,
  output logic wake_irq,
  output logic wake_by_bus
);
  sleep_state_t state;
  logic activity;

  // single ended compares each wire to the mid reference; differential resists noise
  assign activity = wake_source_select ? (activity_a || activity_b) : activity_diff;

  assign sleeping = (state == asleep);
  assign rx_enable = (state == awake);

  // sleep state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= awake;
      wake_irq <= 1'h0;
      wake_by_bus <= 1'h0;
    end
    else if (ce)
    begin
      wake_irq <= 1'h0;
      wake_by_bus <= 1'h0;
      case (state)
        awake:
        begin
          if (sleep_request && !irq_pending && bus_idle)
            state <= asleep;
        end
        asleep:
        begin
          if (!sleep_request)
          begin
            state <= awake;
            wake_irq <= 1'h1;
          end
          else if (activity)
          begin
            state <= wait_bus_free;
            wake_irq <= 1'h1;
            wake_by_bus <= 1'h1;
          end
        end
        wait_bus_free:
        begin
          // the frame that woke us is lost; receive from the next bus-free on
          if (bus_free)
            state <= awake;
        end
        default:
          state <= awake;
      endcase
    end
  end
endmodule : can_sleep_ctrl
`default_nettype wire

//--- can_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module can_engine_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request side
  input wire logic tx_pending,
  input wire logic [3:0] start_delay,
  input wire logic bus_active,
  // engine status
  output logic tx_started,
  output logic tx_in_progress,
  output logic tx_done,
  output logic bus_idle,
  output logic bus_free
);
  logic [3:0] wait_cnt;
  logic [3:0] bit_cnt;
  logic [3:0] idle_cnt;

  // quiet bus: no own frame, no foreign activity; free after eleven quiet bits
  assign bus_idle = !tx_in_progress && !bus_active;
  assign bus_free = idle_cnt == 4'hB;

  // frame starts after a chosen wait, so abort can land before or during it
  always_ff @(posedge aclk)
  begin
    tx_started <= 1'h0;
    tx_done <= 1'h0;
    if (!aresetn)
    begin
      wait_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      tx_in_progress <= 1'h0;
    end
    else if (tx_in_progress)
    begin
      bit_cnt <= bit_cnt + 4'h1;
      tx_in_progress <= bit_cnt != 4'hF;
      tx_done <= bit_cnt == 4'hF;
    end
    else if (!tx_pending)
      wait_cnt <= 4'h0;
    else if (wait_cnt == start_delay)
    begin
      tx_started <= 1'h1;
      tx_in_progress <= 1'h1;
      wait_cnt <= 4'h0;
    end
    else
      wait_cnt <= wait_cnt + 4'h1;
  end

  // quiet-time counter, saturates past the free point
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !bus_idle)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hC)
      idle_cnt <= idle_cnt + 4'h1;
  end
endmodule : can_engine_model
`default_nettype wire

//--- can_command_register_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module can_command_register_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // engine side
  input wire logic tx_started,
  input wire logic tx_in_progress,
  input wire logic tx_done,
  input wire logic rx_message_store,
  input wire logic irq_pending,
  input wire logic bus_idle,
  input wire logic bus_free,
  // commands and levels
  input wire logic transmit_request_cmd,
  input wire logic abort_transmit_cmd,
  input wire logic release_rx_buffer_cmd,
  input wire logic clear_overrun_cmd,
  input wire logic tx_pending,
  input wire logic rx_enable,
  input wire logic rx_drop,
  input wire logic wake_irq,
  input wire logic sleeping,
  // flags
  input wire logic transmit_complete_flag,
  input wire logic rx_buffer_full_flag,
  input wire logic data_overrun_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic any_cmd;
  // any strobe; a held strobe would repeat the command
  assign any_cmd = transmit_request_cmd | abort_transmit_cmd | release_rx_buffer_cmd
    | clear_overrun_cmd;

  // leaving sleep, then the interrupt pulse within a cycle
  sequence s_left_sleep; $fell(sleeping); endsequence
  sequence s_wake_pulse; ##[0:1] wake_irq; endsequence

  property p_cmd_pulse; any_cmd |=> !any_cmd; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("strobe held");
  property p_tc_low; transmit_request_cmd && !tx_done |=> !transmit_complete_flag; endproperty
  a_tc_low: assert property (p_tc_low) else $error("complete not cleared");
  property p_tx_req;
    transmit_request_cmd && !abort_transmit_cmd && !tx_started |=> tx_pending;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("request lost");
  property p_tx_hold; tx_pending && !abort_transmit_cmd && !tx_started |=> tx_pending; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("request dropped");
  property p_abort;
    abort_transmit_cmd && !tx_in_progress && !transmit_request_cmd |=> !tx_pending;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_ovr_set; rx_drop |=> data_overrun_flag; endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");
  property p_ovr_clr; clear_overrun_cmd && !rx_drop |=> !data_overrun_flag; endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
  property p_rx_clr; release_rx_buffer_cmd && !rx_message_store |=> !rx_buffer_full_flag; endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("full not cleared");
  property p_sleep_in; $rose(sleeping) |-> !$past(irq_pending) && $past(bus_idle); endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("slept while busy");
  property p_wake_irq; s_left_sleep |-> s_wake_pulse; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("no wake pulse");
  property p_rx_hold; !rx_enable && !sleeping && !bus_free |=> !rx_enable; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive too early");
endmodule : can_command_register_monitor

bind can_command_register can_command_register_monitor u_monitor (.*);
`default_nettype wire

//--- can_command_register_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "can_cmd_map.svh"
module can_command_register_tb_top;
  import can_cmd_pkg::*;
  // design inputs
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic bus_input_a_active = 1'h0, bus_input_b_active = 1'h0, bus_diff_active = 1'h0;
  logic rx_message_store = 1'h0, irq_pending = 1'h0;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic transmit_request_cmd, abort_transmit_cmd, release_rx_buffer_cmd, clear_overrun_cmd;
  logic tx_pending, rx_enable, rx_drop, wake_irq, comparator_a_from_bus, comparator_b_from_bus;
  logic transmit_complete_flag, transmit_buffer_free_flag, rx_buffer_full_flag;
  logic data_overrun_flag, sleeping;
  // partner model
  logic tx_started, tx_in_progress, tx_done, bus_idle, bus_free, bus_active;
  logic [3:0] start_delay = 4'h1;
  // bench state
  int num_errors = 0, num_checks = 0, wakes = 0;
  logic [1:0] sw = 2'h3;
  logic [1:0] r;
  logic [31:0] d;

  can_command_register DUT (.*);
  can_engine_model u_engine (.*);

  // clock, activity seen by the engine, wake pulse count
  assign bus_active = bus_input_a_active | bus_input_b_active | bus_diff_active;
  always #5 aclk = ~aclk;
  always @(posedge aclk)
    if (wake_irq === 1'h1)
      wakes++;

  function automatic reg_byte_t exp_cmd(input logic [1:0] s, input logic ws, input logic sl);
    return {s, ws, sl, `CMD_READ_ONES};
  endfunction : exp_cmd

  function automatic reg_byte_t exp_st(input logic sl, rxe, tc, tf, ov, rf);
    return {2'h0, rxe, sl, tc, tf, ov, rf};
  endfunction : exp_st

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // write: address and data together, each released once taken
  task automatic wr(input reg_index_t i, input reg_byte_t v, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
    end while (tb !== 1'h1);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input reg_index_t i, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tv;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ta = arready;
      tv = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'h0;
    end while (tv !== 1'h1);
    rready <= 1'h0;
  endtask : rd

  task automatic cmd(input reg_byte_t v);
    wr(`CMD_REG_INDEX, v, r);
    chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask : cmd

  task automatic rchk(input reg_index_t i, input reg_byte_t e, input string n);
    rd(i, d, r);
    chk(n, {24'h0, e}, d);
    chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask : rchk

  task automatic wait_tx(input logic done);
    do
    begin
      @(negedge aclk);
    end while ((done ? tx_done : tx_in_progress) !== 1'h1);
  endtask : wait_tx

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // cut a hang short; the tests need under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    void'($urandom(61033));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(`CMD_REG_INDEX, exp_cmd(2'h3, 1'h0, 1'h0), "cmd reset");
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "status reset");
    rd(6'h03, d, r);
    chk("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    wr(6'h03, 8'hFF, r);
    chk("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("no command", 32'h0, {31'h0, tx_pending});
    $display("done: reset");
    // switches move only here, just after reset, with no traffic running
    for (int k = 3; k >= 0; k--)
    begin
      logic ws;
      ws = 1'($urandom % 2);
      cmd({k[1:0], ws, 5'h00});
      if (k != 0)
        sw = k[1:0];
      rchk(`CMD_REG_INDEX, exp_cmd(sw, ws, 1'h0), "switch read");
      chk("comparator", 32'(sw), {30'h0, comparator_a_from_bus, comparator_b_from_bus});
    end
    $display("done: switches");
    start_delay <= 4'($urandom_range(1, 8));
    cmd(8'h01);
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 0, 0, 0, 0), "tc after request");
    cmd(8'h00);
    chk("still queued", 32'h1, {31'h0, tx_pending | tx_in_progress});
    wait_tx(1'h1);
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "tc after send");
    start_delay <= 4'hF;
    cmd(8'h01);
    cmd(8'h02);
    chk("aborted", 32'h0, {31'h0, tx_pending});
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 0, 1, 0, 0), "tc after abort");
    start_delay <= 4'h1;
    cmd(8'h01);
    wait_tx(1'h0);
    cmd(8'h02);
    wait_tx(1'h1);
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "abort too late");
    $display("done: transmit");
    for (int n = 0; n < 4; n++)
    begin
      @(posedge aclk);
      rx_message_store <= 1'h1;
      @(posedge aclk);
      rx_message_store <= 1'h0;
      if (n == 0)
      begin
        rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 1), "full");
        cmd(8'h04);
        rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "released");
      end
    end
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 1, 1), "overrun");
    cmd(8'h04);
    repeat (3) @(posedge aclk);
    cmd(8'h0C);
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "overrun cleared");
    // a store offered while the enable is low must leave every flag alone
    ce <= 1'h0;
    @(posedge aclk);
    rx_message_store <= 1'h1;
    @(posedge aclk);
    rx_message_store <= 1'h0;
    ce <= 1'h1;
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "frozen store");
    $display("done: receive");
    irq_pending <= 1'h1;
    cmd(8'h10);
    rchk(`CMD_REG_INDEX, exp_cmd(sw, 1'h0, 1'h0), "sleep blocked");
    irq_pending <= 1'h0;
    cmd(8'h10);
    rchk(`CMD_REG_INDEX, exp_cmd(sw, 1'h0, 1'h1), "asleep");
    cmd(8'h00);
    rchk(`STATUS_REG_INDEX, exp_st(0, 1, 1, 1, 0, 0), "awake");
    for (int w = 0; w < 2; w++)
    begin
      cmd({2'h0, w[0], 1'h1, 4'h0});
      {bus_input_a_active, bus_input_b_active, bus_diff_active} <= w[0] ? 3'h1 : 3'h4;
      repeat (6) @(posedge aclk);
      chk("wrong source", 32'h1, {31'h0, sleeping});
      {bus_input_a_active, bus_input_b_active, bus_diff_active} <=
        w[0] ? (3'h4 >> ($urandom % 2)) : 3'h1;
      repeat (6) @(posedge aclk);
      chk("woken", 32'h0, {31'h0, sleeping});
      chk("rx held", 32'h0, {31'h0, rx_enable});
      {bus_input_a_active, bus_input_b_active, bus_diff_active} <= 3'h0;
      repeat (20) @(posedge aclk);
      chk("rx back", 32'h1, {31'h0, rx_enable});
      rchk(`CMD_REG_INDEX, exp_cmd(sw, w[0], 1'h0), "sleep bit");
    end
    chk("wake pulses", 32'h3, wakes);
    $display("done: sleep");
    end_of_test();
  end
endmodule : can_command_register_tb_top
`default_nettype wire
